// File: rtl/hpsp_pkg.sv
// Package: configuration fields and structs for the host port strobe pins
package hpsp_pkg;
    localparam int CTRL_W = 16;
    // Port control register field positions
    localparam int CTL_HOST_EN = 0;
    localparam int CTL_DUAL_STROBE = 1;
    localparam int CTL_DUAL_REQ = 2;
    localparam int CTL_REQ_OD = 3;
    localparam int CTL_POL_DS = 4;
    localparam int CTL_POL_RD = 5;
    localparam int CTL_POL_WR = 6;
    localparam int CTL_POL_REQ = 7;
    localparam int CTL_POL_TXRQ = 8;
    localparam int CTL_POL_RXRQ = 9;
    localparam int CTL_POL_ACK = 10;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    // Pin indices within the four-pin group
    localparam int NPIN = 4;
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_C = 2;
    localparam int PIN_D = 3;
    localparam logic [3:0] PIN_RST = 4'h0;

    typedef struct packed {
        logic readNotWrite;
        logic accessStrobe;
        logic readStrobe;
        logic writeStrobe;
        logic acknowledge;
    } hpsp_host_ev_t;

    typedef struct packed {
        logic combined;
        logic tx;
        logic rx;
    } hpsp_req_t;

    typedef struct packed {
        logic [3:0] o;
        logic [3:0] oe;
    } hpsp_pins_t;
endpackage : hpsp_pkg

// File: rtl/hpsp_sync.sv
// Two-flop synchroniser for the pin inputs
`timescale 1ns/10ps
module hpsp_sync
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] asyncIn,
    output logic [3:0] syncOut
);
    logic [3:0] meta_r;
    logic [3:0] meta_nxt;
    logic [3:0] sync_r;
    logic [3:0] sync_nxt;

    always_comb
    begin
        meta_nxt = asyncIn;
        sync_nxt = meta_r;
        if (!rst_n)
        begin
            meta_nxt = hpsp_pkg::PIN_RST;
            sync_nxt = hpsp_pkg::PIN_RST;
        end
    end

    always_ff @(posedge core_clk)
    begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
    end

    assign syncOut = sync_r;
endmodule : hpsp_sync

// File: rtl/hpsp_top.sv
// Host port strobe, request and acknowledge pin configuration logic
// Functional notes
// - single strobe: pin A gives read/write
// - dual strobe: pin A is read strobe
// - single strobe: pin B qualifies each access
// - dual strobe: pin B is write strobe
// - single request: pin C drives combined request
// - dual request: pin C drives transmit request
// - dual request: pin D drives receive request
// - requests selectable driven or open-drain
// - GPIO mode: pins are per-bit direction ports
// - stop: former inputs stay ignored
// - stop: former outputs keep last level
// - wait state leaves pins unchanged
// - pin function follows 16-bit control word
`timescale 1ns/10ps
module hpsp_top
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [15:0] portCtrl,
    input wire logic [3:0] gpioDir,
    input wire logic [3:0] gpioOut,
    input wire logic stopMode,
    input wire logic waitMode,
    input wire logic [3:0] pinIn,
    input wire logic reqCombined,
    input wire logic reqTx,
    input wire logic reqRx,
    output logic [3:0] pinOut,
    output logic [3:0] pinOe,
    output logic [3:0] gpioIn,
    output hpsp_pkg::hpsp_host_ev_t hostEv,
    output logic waitSeen
);
    logic [3:0] pinSync;
    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    hpsp_pkg::hpsp_pins_t pins_r;
    hpsp_pkg::hpsp_pins_t pins_nxt;
    hpsp_pkg::hpsp_host_ev_t ev_r;
    hpsp_pkg::hpsp_host_ev_t ev_nxt;
    logic [3:0] gin_r;
    logic [3:0] gin_nxt;
    logic wait_r;
    logic wait_nxt;
    logic hostEn;
    logic dualStb;
    logic dualReq;
    logic reqOd;
    hpsp_pkg::hpsp_req_t reqPin;
    logic [3:0] drvLevel;
    logic [3:0] drvEn;
    logic [3:0] inMask;

    hpsp_sync u_sync
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .asyncIn(pinIn),
        .syncOut(pinSync)
    );

    // Control word registered; frozen while stopped so pins hold
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (!rst_n)
            ctrl_nxt = hpsp_pkg::CTRL_RST;
        else if (!stopMode)
            ctrl_nxt = portCtrl;
    end

    always_ff @(posedge core_clk)
    begin
        ctrl_r <= ctrl_nxt;
    end

    assign hostEn = ctrl_r[hpsp_pkg::CTL_HOST_EN];
    assign dualStb = ctrl_r[hpsp_pkg::CTL_DUAL_STROBE];
    assign dualReq = ctrl_r[hpsp_pkg::CTL_DUAL_REQ];
    assign reqOd = ctrl_r[hpsp_pkg::CTL_REQ_OD];

    // Polarity bit zero means active-low at the pin
    assign reqPin.combined = reqCombined ~^ ctrl_r[hpsp_pkg::CTL_POL_REQ];
    assign reqPin.tx = reqTx ~^ ctrl_r[hpsp_pkg::CTL_POL_TXRQ];
    assign reqPin.rx = reqRx ~^ ctrl_r[hpsp_pkg::CTL_POL_RXRQ];

    always_comb
    begin
        drvLevel = gpioOut;
        drvEn = gpioDir;
        if (hostEn)
        begin
            drvLevel = 4'h0;
            drvEn = 4'h0;
            if (dualReq)
            begin
                drvLevel[hpsp_pkg::PIN_C] = reqPin.tx;
                drvLevel[hpsp_pkg::PIN_D] = reqPin.rx;
                drvEn[hpsp_pkg::PIN_C] = 1'b1;
                drvEn[hpsp_pkg::PIN_D] = 1'b1;
            end
            else
            begin
                drvLevel[hpsp_pkg::PIN_C] = reqPin.combined;
                drvEn[hpsp_pkg::PIN_C] = 1'b1;
            end
            // Open-drain only pulls low; high is released to the pull-up
            if (reqOd)
                drvEn = drvEn & ~drvLevel;
        end
    end

    // Pins read as GPIO inputs in the present configuration; none in host mode
    assign inMask = hostEn ? 4'h0 : ~gpioDir;

    always_comb
    begin
        pins_nxt = pins_r;
        if (!rst_n)
        begin
            pins_nxt.o = hpsp_pkg::PIN_RST;
            pins_nxt.oe = hpsp_pkg::PIN_RST;
        end
        else if (!stopMode)
        begin
            pins_nxt.o = drvLevel;
            pins_nxt.oe = drvEn;
        end
        // Stop: last level and enable held, standing in for the keeper
    end

    always_ff @(posedge core_clk)
    begin
        pins_r <= pins_nxt;
    end

    // Input decode; ignored in stop and in reset
    always_comb
    begin
        ev_nxt = ev_r;
        gin_nxt = gin_r;
        if (!rst_n)
        begin
            ev_nxt = '0;
            gin_nxt = hpsp_pkg::PIN_RST;
        end
        else if (!stopMode)
        begin
            ev_nxt = '0;
            gin_nxt = (pinSync & inMask) | (pins_r.o & ~inMask);
            if (hostEn)
            begin
                gin_nxt = 4'h0;
                if (dualStb)
                begin
                    ev_nxt.readStrobe = pinSync[hpsp_pkg::PIN_A] ~^
                        ctrl_r[hpsp_pkg::CTL_POL_RD];
                    ev_nxt.writeStrobe = pinSync[hpsp_pkg::PIN_B] ~^
                        ctrl_r[hpsp_pkg::CTL_POL_WR];
                    ev_nxt.accessStrobe = ev_nxt.readStrobe | ev_nxt.writeStrobe;
                    ev_nxt.readNotWrite = ev_nxt.readStrobe;
                end
                else
                begin
                    ev_nxt.readNotWrite = pinSync[hpsp_pkg::PIN_A];
                    ev_nxt.accessStrobe = pinSync[hpsp_pkg::PIN_B] ~^
                        ctrl_r[hpsp_pkg::CTL_POL_DS];
                    ev_nxt.readStrobe = ev_nxt.accessStrobe & ev_nxt.readNotWrite;
                    ev_nxt.writeStrobe = ev_nxt.accessStrobe & ~ev_nxt.readNotWrite;
                end
                if (!dualReq)
                    ev_nxt.acknowledge = pinSync[hpsp_pkg::PIN_D] ~^
                        ctrl_r[hpsp_pkg::CTL_POL_ACK];
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        ev_r <= ev_nxt;
        gin_r <= gin_nxt;
    end

    // Wait is only reported; it has no path into the pin logic
    always_comb
    begin
        wait_nxt = rst_n ? waitMode : 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        wait_r <= wait_nxt;
    end

    assign pinOut = pins_r.o;
    assign pinOe = pins_r.oe;
    assign gpioIn = gin_r;
    assign hostEv = ev_r;
    assign waitSeen = wait_r;

    a_reset_undriven: assert property (@(posedge core_clk) !rst_n |=> pinOe == 4'h0)
        else $error("pin driven after reset cycle");
    a_stop_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
        stopMode && $past(stopMode) |-> $stable(pinOut) && $stable(pinOe))
        else $error("pin changed during stop");
    a_stop_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
        stopMode ##1 stopMode |-> $stable(gpioIn) && $stable(hostEv))
        else $error("input seen during stop");
    a_wait_noeffect: assert property (@(posedge core_clk) disable iff (!rst_n)
        !stopMode && $stable(portCtrl) && $stable(gpioDir) && $stable(gpioOut)
        && $stable(reqCombined) && $stable(reqTx) && $stable(reqRx) && !$stable(waitMode)
        ##1 !stopMode |=> $stable(pinOut) && $stable(pinOe))
        else $error("wait changed a pin");
    a_gpio_dir: assert property (@(posedge core_clk) disable iff (!rst_n)
        !stopMode && !portCtrl[hpsp_pkg::CTL_HOST_EN] ##1 !stopMode
        |=> pinOe == $past(gpioDir) && pinOut == $past(gpioOut))
        else $error("gpio pin drive mismatch");
    a_single_req: assert property (@(posedge core_clk) disable iff (!rst_n)
        !stopMode && hostEn && !dualReq && !reqOd
        |=> pinOe[hpsp_pkg::PIN_C] && pinOut[hpsp_pkg::PIN_C] ==
        ($past(reqCombined) ~^ $past(ctrl_r[hpsp_pkg::CTL_POL_REQ])))
        else $error("combined request wrong");
    a_dual_req: assert property (@(posedge core_clk) disable iff (!rst_n)
        !stopMode && hostEn && dualReq && !reqOd
        |=> pinOe[hpsp_pkg::PIN_D] && pinOut[hpsp_pkg::PIN_D] ==
        ($past(reqRx) ~^ $past(ctrl_r[hpsp_pkg::CTL_POL_RXRQ])))
        else $error("receive request wrong");
    a_tx_req: assert property (@(posedge core_clk) disable iff (!rst_n)
        !stopMode && hostEn && dualReq && !reqOd
        |=> pinOut[hpsp_pkg::PIN_C] ==
        ($past(reqTx) ~^ $past(ctrl_r[hpsp_pkg::CTL_POL_TXRQ])))
        else $error("transmit request wrong");
    a_open_drain: assert property (@(posedge core_clk) disable iff (!rst_n)
        !stopMode && hostEn && reqOd |=> (pinOe & pinOut) == 4'h0)
        else $error("open-drain drove high");
    a_strobe_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        !stopMode && hostEn && dualStb && !ctrl_r[hpsp_pkg::CTL_POL_RD]
        |=> hostEv.readStrobe == !$past(pinSync[hpsp_pkg::PIN_A]))
        else $error("read strobe polarity wrong");

    c_gpio: cover property (@(posedge core_clk) rst_n && !hostEn && pinOe != 4'h0);
    c_dual_write: cover property (@(posedge core_clk) rst_n && dualStb && hostEv.writeStrobe);
    c_ack: cover property (@(posedge core_clk) rst_n && hostEv.acknowledge);
    c_stop: cover property (@(posedge core_clk) rst_n && stopMode [*3]);
endmodule : hpsp_top

// File: tb/hpsp_host_model.sv
// Host bus model: drives strobes and acknowledge, resolves shared pins
`timescale 1ns/10ps
module hpsp_host_model
(
    input wire logic [3:0] pinOut,
    input wire logic [3:0] pinOe,
    input wire logic [3:0] hostLvl,
    input wire logic [3:0] hostEn,
    output logic [3:0] pinIn
);
    // Pull-up on every line, so open-drain requests float high
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            pinIn[i] = pinOe[i] ? pinOut[i] : (hostEn[i] ? hostLvl[i] : 1'b1);
        end
    end
endmodule : hpsp_host_model

// File: tb/tb.sv
// Self-checking bench for the host port pin logic
`timescale 1ns/10ps
module tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] portCtrl = 16'h0000;
    logic [3:0] gpioDir = 4'h0, gpioOut = 4'h0, hostLvl = 4'hf, hostEn = 4'h0;
    logic stopMode = 1'b0, waitMode = 1'b0, reqCombined = 1'b0, reqTx = 1'b0, reqRx = 1'b0;
    logic [3:0] pinIn, pinOut, pinOe, gpioIn;
    hpsp_pkg::hpsp_host_ev_t hostEv;
    logic waitSeen;
    int errors = 0, checks = 0, cycles = 0;
    initial
    begin
        forever #2 core_clk = ~core_clk;
    end
    hpsp_top u_hpsp_top (.core_clk(core_clk), .rst_n(rst_n), .portCtrl(portCtrl),
        .gpioDir(gpioDir), .gpioOut(gpioOut), .stopMode(stopMode), .waitMode(waitMode),
        .pinIn(pinIn), .reqCombined(reqCombined), .reqTx(reqTx), .reqRx(reqRx),
        .pinOut(pinOut), .pinOe(pinOe), .gpioIn(gpioIn), .hostEv(hostEv), .waitSeen(waitSeen));
    hpsp_host_model u_hpsp_host_model (.pinOut(pinOut), .pinOe(pinOe), .hostLvl(hostLvl),
        .hostEn(hostEn), .pinIn(pinIn));
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge core_clk)
    begin
        cycles++;
        // Whole run needs just under a hundred cycles
        if (cycles == 2000)
        begin
            errors++;
            $display("[ERR] %0t timeout", $time);
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    // Four edges cover the three-cycle pin-to-event path
    task automatic apply(input logic [15:0] c, input logic [3:0] lvl, en, dir, gout,
        input logic [2:0] rq, input logic st, wt);
        @(posedge core_clk);
        portCtrl <= c;
        hostLvl <= lvl;
        hostEn <= en;
        gpioDir <= dir;
        gpioOut <= gout;
        {reqCombined, reqTx, reqRx} <= rq;
        stopMode <= st;
        waitMode <= wt;
        tick(4);
    endtask : apply
    task automatic t_reset();
        tick(3);
        chk({pinOe, pinOut, gpioIn}, 16'h0000);
        chk(hostEv, 16'h0000);
        tick(4);
        @(posedge core_clk);
        rst_n <= 1'b1;
    endtask : t_reset
    task automatic t_single_strobe();
        apply(16'h0001, 4'h1, 4'h3, 4'h0, 4'h0, 3'h0, 1'b0, 1'b0);
        chk({hostEv.readNotWrite, hostEv.accessStrobe}, 16'h0003);
        apply(16'h0001, 4'h0, 4'h3, 4'h0, 4'h0, 3'h0, 1'b0, 1'b0);
        chk({hostEv.readNotWrite, hostEv.accessStrobe}, 16'h0001);
        apply(16'h0011, 4'h2, 4'h3, 4'h0, 4'h0, 3'h0, 1'b0, 1'b0);
        chk(hostEv.accessStrobe, 16'h0001);
    endtask : t_single_strobe
    task automatic t_dual_strobe();
        apply(16'h0003, 4'h2, 4'h3, 4'h0, 4'h0, 3'h0, 1'b0, 1'b0);
        chk({hostEv.readStrobe, hostEv.writeStrobe}, 16'h0002);
        apply(16'h0003, 4'h1, 4'h3, 4'h0, 4'h0, 3'h0, 1'b0, 1'b0);
        chk({hostEv.readStrobe, hostEv.writeStrobe}, 16'h0001);
        apply(16'h0063, 4'h1, 4'h3, 4'h0, 4'h0, 3'h0, 1'b0, 1'b0);
        chk({hostEv.readStrobe, hostEv.writeStrobe}, 16'h0002);
    endtask : t_dual_strobe
    task automatic t_requests();
        apply(16'h0001, 4'h0, 4'h0, 4'h0, 4'h0, 3'h4, 1'b0, 1'b0);
        chk({pinOe[2], pinOut[2]}, 16'h0002);
        apply(16'h0081, 4'h0, 4'h0, 4'h0, 4'h0, 3'h4, 1'b0, 1'b0);
        chk({pinOe[2], pinOut[2]}, 16'h0003);
        apply(16'h0009, 4'h0, 4'h0, 4'h0, 4'h0, 3'h4, 1'b0, 1'b0);
        chk({pinOe[2], pinOut[2]}, 16'h0002);
        apply(16'h0009, 4'h0, 4'h0, 4'h0, 4'h0, 3'h0, 1'b0, 1'b0);
        chk(pinOe[2], 16'h0000);
        apply(16'h0005, 4'h0, 4'h0, 4'h0, 4'h0, 3'h2, 1'b0, 1'b0);
        chk({pinOe[3:2], pinOut[3:2]}, 16'h000e);
        apply(16'h0305, 4'h0, 4'h0, 4'h0, 4'h0, 3'h2, 1'b0, 1'b0);
        chk({pinOe[3:2], pinOut[3:2]}, 16'h000d);
    endtask : t_requests
    task automatic t_ack();
        apply(16'h0001, 4'h0, 4'h8, 4'h0, 4'h0, 3'h0, 1'b0, 1'b0);
        chk(hostEv.acknowledge, 16'h0001);
        apply(16'h0401, 4'h0, 4'h8, 4'h0, 4'h0, 3'h0, 1'b0, 1'b0);
        chk(hostEv.acknowledge, 16'h0000);
    endtask : t_ack
    // Pins A and C out, B and D in; stop then freezes all of it
    task automatic t_gpio_stop_wait();
        apply(16'h0000, 4'h2, 4'ha, 4'h5, 4'h1, 3'h0, 1'b0, 1'b0);
        chk({pinOe, pinOut & 4'h5, gpioIn}, 16'h0513);
        apply(16'h0000, 4'h2, 4'ha, 4'h5, 4'h1, 3'h0, 1'b0, 1'b1);
        chk({pinOe, pinOut & 4'h5, gpioIn}, 16'h0513);
        chk(waitSeen, 16'h0001);
        apply(16'h0000, 4'h8, 4'ha, 4'h0, 4'h4, 3'h0, 1'b1, 1'b0);
        chk({pinOe, pinOut & 4'h5}, 16'h0051);
        chk(gpioIn, 16'h0003);
        apply(16'h0000, 4'h8, 4'ha, 4'h0, 4'h4, 3'h0, 1'b0, 1'b0);
        chk(pinOe, 16'h0000);
    endtask : t_gpio_stop_wait
    initial
    begin
        t_reset();
        t_single_strobe();
        t_dual_strobe();
        t_requests();
        t_ack();
        t_gpio_stop_wait();
        tally_and_finish();
    end
endmodule : tb
